// ==== inc/tcpu_pkg.sv ====
package tcpu_pkg;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    // ==========================================================
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CAPCTL = 8'h04;
    localparam logic [7:0] OFS_OUTCTL = 8'h08;
    localparam logic [7:0] OFS_PRESC = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_REG_A = 8'h14;
    localparam logic [7:0] OFS_REG_B = 8'h18;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int OUT_EN_BIT = 0;
    localparam int OUT_OS_EN_BIT = 5;
    localparam int OUT_OS_TRIG_BIT = 6;

    // ==========================================================
    // Encodings and reset values
    // ==========================================================
    localparam logic [1:0] OP_STOP = 2'h0;
    localparam logic [1:0] OP_FREE = 2'h1;
    localparam logic [1:0] OP_EDGE_CLEAR = 2'h2;
    localparam logic [1:0] OP_PPG = 2'h3;
    localparam logic [1:0] ES_FALL = 2'h0;
    localparam logic [1:0] ES_RISE = 2'h1;
    localparam logic [1:0] ES_BOTH = 2'h3;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] RST_CAPCMP = 16'h0000;
    localparam logic [2:0] RST_DIV = 3'h0;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_evt_t;

    // Bits 3..0 of the mode control register
    typedef struct packed {
        logic [1:0] op_mode;
        logic capture_toggle_enable;
        logic overflow_flag;
    } mode_ctl_t;

    // Bits 2..0 of the capture/compare control register
    typedef struct packed {
        logic b_capture;
        logic reverse_phase_capture_sel;
        logic a_capture;
    } cap_ctl_t;

    // Bits 7..0 of the prescaler mode register
    typedef struct packed {
        logic [1:0] es_b;
        logic [1:0] es_a;
        logic [1:0] rsvd;
        logic [1:0] div_sel;
    } presc_t;

    localparam mode_ctl_t RST_MODE = 4'h0;
    localparam cap_ctl_t RST_CAPCTL = 3'h0;
    localparam presc_t RST_PRESC = 8'h00;

endpackage : tcpu_pkg

// ==== rtl/trig_edge_detect.sv ====
`timescale 1ns/10ps
module trig_edge_detect (
    input wire logic pclk,                       // system clock
    input wire logic presetn,                    // async reset, active low
    input wire logic pin,                        // raw trigger level
    output tcpu_pkg::edge_evt_t evt              // registered edge pulses
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    tcpu_pkg::edge_evt_t evt_d;
    tcpu_pkg::edge_evt_t evt_q;

    // ==========================================================
    // Edge detection, only on the second synchroniser stage
    // ==========================================================
    always_comb begin
        evt_d.rise = sync2_q & ~prev_q;
        evt_d.fall = ~sync2_q & prev_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            evt_q <= '0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            evt_q <= evt_d;
        end
    end

    assign evt = evt_q;

endmodule : trig_edge_detect

// ==== rtl/timer_capture_pulse_unit.sv ====
// What this block does
// - Dual capture free-running: output holds, toggles on input A edge if enabled
// - Dual capture free-running: input A edge captures B, input B edge captures A
// - Dual capture with only input B edges: register B never captures
// - Register A capture trigger selectable: input A reverse phase or input B
// - Register B captures only on valid input A edge
// - Free-running compare matches raise their interrupt, never clear counter
// - Counter readable anytime without disturbing counting
// - Mode 11 clears counter on A match and drives a pulse, toggling output on A and B matches
// - Pulse period A plus one, low width B plus one count clocks
// - Pulse mode A match raises interrupt A and clears counter
// - Pulse mode B match raises interrupt B, counter keeps counting
// - One-shot enabled in mode 01 or 10 with one-shot enable bit 5
// - Soft trigger bit 6 or input A edge restarts counter, one pulse
// - One-shot A and B matches raise their interrupt and invert output
// - One-shot delay A plus one, width B minus A count clocks
// - Width measurement works free-running and with input A restart
// - Mode 01 counts up, wraps after FFFFH and sets overflow flag
// - Reverse phase select: A captures on opposite edge, no interrupt A
// - Edge select: 00 falling, 01 rising, 10 none, 11 both
// - Mode 10: input A edge captures into B and clears counter
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module timer_capture_pulse_unit (
    input wire logic pclk,                       // 20 MHz system clock
    input wire logic presetn,                    // async reset, active low
    input wire logic psel,                       // APB select
    input wire logic penable,                    // APB enable
    input wire logic pwrite,                     // APB direction
    input wire logic [7:0] paddr,                // APB byte address
    input wire logic [31:0] pwdata,              // APB write data
    output logic [31:0] prdata,                  // APB read data
    output logic pready,                         // APB ready
    output logic pslverr,                        // APB error, unmapped address
    input wire logic trigger_input_a,            // external trigger A
    input wire logic trigger_input_b,            // external trigger B
    output logic timer_output_pin,               // toggle output
    output logic irq_reg_a,                      // one-cycle event, register A
    output logic irq_reg_b                       // one-cycle event, register B
);

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic logic edge_hit(input logic [1:0] sel, input tcpu_pkg::edge_evt_t e);
        case (sel)
            tcpu_pkg::ES_FALL: edge_hit = e.fall;
            tcpu_pkg::ES_RISE: edge_hit = e.rise;
            tcpu_pkg::ES_BOTH: edge_hit = e.rise | e.fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    function automatic logic [2:0] div_last(input logic [1:0] sel);
        div_last = 3'((4'h1 << sel) - 4'h1);
    endfunction : div_last

    // ==========================================================
    // State
    // ==========================================================
    tcpu_pkg::mode_ctl_t mode_q, mode_d;
    tcpu_pkg::cap_ctl_t cap_q, cap_d;
    tcpu_pkg::presc_t presc_q, presc_d;
    tcpu_pkg::edge_evt_t evt_a, evt_b, pend_a_q, pend_a_d, pend_b_q, pend_b_d;
    tcpu_pkg::edge_evt_t cur_a, cur_b;
    logic out_en_q, out_en_d, os_en_q, os_en_d, soft_q, soft_d;
    logic [15:0] cnt_q, cnt_d, reg_a_q, reg_a_d, reg_b_q, reg_b_d;
    logic [2:0] div_q, div_d;
    logic armed_q, armed_d, out_q, out_d;
    logic irq_a_q, irq_a_d, irq_b_q, irq_b_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic wr, setup, mapped, running, tick, os_on, os_trig;
    logic valid_a, valid_b, rev_a, match_a, match_b, clear, ovf_set;
    logic cap_a, cap_b, toggle;

    trig_edge_detect u_edge_a (
        .pclk(pclk),
        .presetn(presetn),
        .pin(trigger_input_a),
        .evt(evt_a)
    );

    trig_edge_detect u_edge_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin(trigger_input_b),
        .evt(evt_b)
    );

    // ==========================================================
    // Event decode at each count clock
    // ==========================================================
    always_comb begin
        running = mode_q.op_mode != tcpu_pkg::OP_STOP;
        tick = running && (div_q == div_last(presc_q.div_sel));
        // Edges seen between count clocks are held so none is lost
        cur_a = pend_a_q | evt_a;
        cur_b = pend_b_q | evt_b;
        valid_a = tick && edge_hit(presc_q.es_a, cur_a);
        valid_b = tick && edge_hit(presc_q.es_b, cur_b);
        rev_a = tick && edge_hit(presc_q.es_a, {cur_a.fall, cur_a.rise});
        os_on = os_en_q && (mode_q.op_mode == tcpu_pkg::OP_FREE ||
                            mode_q.op_mode == tcpu_pkg::OP_EDGE_CLEAR);
        os_trig = tick && os_on && (soft_q || valid_a);
        match_a = tick && !cap_q.a_capture && cnt_q == reg_a_q;
        match_b = tick && !cap_q.b_capture && cnt_q == reg_b_q;
        clear = os_trig ||
                (mode_q.op_mode == tcpu_pkg::OP_EDGE_CLEAR && valid_a) ||
                (mode_q.op_mode == tcpu_pkg::OP_PPG && match_a);
        ovf_set = tick && !clear && cnt_q == tcpu_pkg::CNT_MAX;
        cap_b = cap_q.b_capture && valid_a;
        cap_a = cap_q.a_capture &&
                (cap_q.reverse_phase_capture_sel ? rev_a : valid_b);
    end

    // ==========================================================
    // Counter, capture registers, events
    // ==========================================================
    always_comb begin
        pend_a_d = tick ? '0 : cur_a;
        pend_b_d = tick ? '0 : cur_b;
        div_d = (!running || tick) ? tcpu_pkg::RST_DIV : 3'(div_q + 3'h1);
        cnt_d = cnt_q;
        if (!running) begin
            cnt_d = tcpu_pkg::CNT_ZERO;
        end else if (tick) begin
            cnt_d = clear ? tcpu_pkg::CNT_ZERO : 16'(cnt_q + 16'h0001);
        end
        // A capture outranks a software write in the same cycle
        reg_a_d = reg_a_q;
        if (cap_a) begin
            reg_a_d = cnt_q;
        end else if (wr && paddr == tcpu_pkg::OFS_REG_A) begin
            reg_a_d = pwdata[15:0];
        end
        reg_b_d = reg_b_q;
        if (cap_b) begin
            reg_b_d = cnt_q;
        end else if (wr && paddr == tcpu_pkg::OFS_REG_B) begin
            reg_b_d = pwdata[15:0];
        end
        // Reverse phase capture stays silent; an input B edge still signals
        irq_a_d = match_a || (cap_q.a_capture && valid_b);
        irq_b_d = match_b || cap_b;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a_q <= '0;
            pend_b_q <= '0;
            div_q <= tcpu_pkg::RST_DIV;
            cnt_q <= tcpu_pkg::CNT_ZERO;
            reg_a_q <= tcpu_pkg::RST_CAPCMP;
            reg_b_q <= tcpu_pkg::RST_CAPCMP;
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            pend_a_q <= pend_a_d;
            pend_b_q <= pend_b_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            reg_a_q <= reg_a_d;
            reg_b_q <= reg_b_d;
            irq_a_q <= irq_a_d;
            irq_b_q <= irq_b_d;
        end
    end

    // ==========================================================
    // Output toggle register
    // ==========================================================
    always_comb begin
        armed_d = armed_q;
        if (os_on) begin
            // One pulse per trigger: matches outside the armed window are ignored
            toggle = armed_q && !os_trig && (match_a || match_b);
            if (os_trig) begin
                armed_d = 1'b1;
            end else if (armed_q && match_b) begin
                armed_d = 1'b0;
            end
        end else begin
            toggle = match_a || match_b ||
                     (mode_q.op_mode == tcpu_pkg::OP_EDGE_CLEAR && valid_a) ||
                     (cap_q.a_capture && cap_q.b_capture &&
                      mode_q.capture_toggle_enable && valid_a);
            armed_d = 1'b0;
        end
        out_d = out_q ^ (toggle && out_en_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
            out_q <= out_d;
        end
    end

    // ==========================================================
    // APB slave and configuration
    // ==========================================================
    always_comb begin
        wr = psel && penable && pwrite;
        setup = psel && !penable;
        mapped = paddr == tcpu_pkg::OFS_MODE || paddr == tcpu_pkg::OFS_CAPCTL ||
                 paddr == tcpu_pkg::OFS_OUTCTL || paddr == tcpu_pkg::OFS_PRESC ||
                 paddr == tcpu_pkg::OFS_COUNT || paddr == tcpu_pkg::OFS_REG_A ||
                 paddr == tcpu_pkg::OFS_REG_B;
        mode_d = mode_q;
        cap_d = cap_q;
        presc_d = presc_q;
        out_en_d = out_en_q;
        os_en_d = os_en_q;
        soft_d = soft_q && !tick;
        if (wr && paddr == tcpu_pkg::OFS_MODE) begin
            mode_d = pwdata[3:0];
            // Software may only clear the flag
            mode_d.overflow_flag = pwdata[0] && mode_q.overflow_flag;
        end
        // A wrap in the same cycle as a clear still sets the flag
        if (ovf_set) begin
            mode_d.overflow_flag = 1'b1;
        end
        if (wr && paddr == tcpu_pkg::OFS_CAPCTL) begin
            cap_d = pwdata[2:0];
        end
        if (wr && paddr == tcpu_pkg::OFS_PRESC) begin
            presc_d = pwdata[7:0];
            presc_d.rsvd = 2'h0;
        end
        if (wr && paddr == tcpu_pkg::OFS_OUTCTL) begin
            out_en_d = pwdata[tcpu_pkg::OUT_EN_BIT];
            os_en_d = pwdata[tcpu_pkg::OUT_OS_EN_BIT];
            soft_d = soft_q || pwdata[tcpu_pkg::OUT_OS_TRIG_BIT];
        end
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            err_d = !mapped;
            case (paddr)
                tcpu_pkg::OFS_MODE: rdata_d = {28'h0000000, mode_q};
                tcpu_pkg::OFS_CAPCTL: rdata_d = {29'h0, cap_q};
                tcpu_pkg::OFS_OUTCTL: rdata_d = {25'h0, 1'b0, os_en_q, 4'h0, out_en_q};
                tcpu_pkg::OFS_PRESC: rdata_d = {24'h000000, presc_q};
                tcpu_pkg::OFS_COUNT: rdata_d = {16'h0000, cnt_q};
                tcpu_pkg::OFS_REG_A: rdata_d = {16'h0000, reg_a_q};
                tcpu_pkg::OFS_REG_B: rdata_d = {16'h0000, reg_b_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= tcpu_pkg::RST_MODE;
            cap_q <= tcpu_pkg::RST_CAPCTL;
            presc_q <= tcpu_pkg::RST_PRESC;
            out_en_q <= 1'b0;
            os_en_q <= 1'b0;
            soft_q <= 1'b0;
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            cap_q <= cap_d;
            presc_q <= presc_d;
            out_en_q <= out_en_d;
            os_en_q <= os_en_d;
            soft_q <= soft_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = err_q && psel && penable;
    assign timer_output_pin = out_q;
    assign irq_reg_a = irq_a_q;
    assign irq_reg_b = irq_b_q;

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_wrap;
        tick && !clear && cnt_q == tcpu_pkg::CNT_MAX;
    endsequence

    sequence s_restart;
        tick && os_on && (soft_q || valid_a);
    endsequence

    chk_ovf_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        s_wrap |=> mode_q.overflow_flag && cnt_q == tcpu_pkg::CNT_ZERO)
        else $error("overflow flag or wrap missing");

    chk_oneshot_restart: assert property (@(posedge pclk) disable iff (!presetn)
        s_restart |=> cnt_q == tcpu_pkg::CNT_ZERO && armed_q)
        else $error("one-shot trigger did not restart counter");

    chk_capb_value: assert property (@(posedge pclk) disable iff (!presetn)
        tick && cap_q.b_capture && valid_a |=> reg_b_q == $past(cnt_q) && irq_reg_b)
        else $error("register B capture wrong");

    chk_capa_value: assert property (@(posedge pclk) disable iff (!presetn)
        cap_a |=> reg_a_q == $past(cnt_q))
        else $error("register A capture wrong");

    chk_ppg_clear: assert property (@(posedge pclk) disable iff (!presetn)
        tick && mode_q.op_mode == tcpu_pkg::OP_PPG && !cap_q.a_capture && cnt_q == reg_a_q
        |=> irq_reg_a && cnt_q == tcpu_pkg::CNT_ZERO)
        else $error("pulse mode A match did not clear");

    chk_ppg_b_noclear: assert property (@(posedge pclk) disable iff (!presetn)
        tick && mode_q.op_mode == tcpu_pkg::OP_PPG && match_b && !match_a
        |=> irq_reg_b && cnt_q == 16'($past(cnt_q) + 16'h0001))
        else $error("pulse mode B match cleared counter");

    chk_free_count: assert property (@(posedge pclk) disable iff (!presetn)
        tick && mode_q.op_mode == tcpu_pkg::OP_FREE && !clear && psel
        |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
        else $error("counter disturbed during bus access");

    chk_dualcap_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !os_on && cap_q.a_capture && cap_q.b_capture &&
        mode_q.op_mode == tcpu_pkg::OP_FREE && !mode_q.capture_toggle_enable
        |=> $stable(timer_output_pin))
        else $error("output moved in dual capture mode");

    chk_rev_silent: assert property (@(posedge pclk) disable iff (!presetn)
        cap_q.a_capture && cap_q.reverse_phase_capture_sel && rev_a && !valid_b
        |=> !irq_reg_a)
        else $error("reverse phase capture raised interrupt A");

endmodule : timer_capture_pulse_unit

// ==== bench/pulse_source.sv ====
`timescale 1ns/10ps
// ==========================================================
// External trigger sources and load on the output pin
module pulse_source (
    input wire logic pclk,              // system clock
    input wire logic presetn,           // async reset, active low
    input wire logic flip_a,            // invert trigger A at next edge
    input wire logic flip_b,            // invert trigger B at next edge
    input wire logic timer_output_pin,  // observed load
    output logic trigger_input_a,       // trigger A level
    output logic trigger_input_b,       // trigger B level
    output int toggles,                 // output edges seen
    output int gap                      // cycles between last two output edges
);
    logic out_q;
    int cyc_q;
    int last_q;
    // Levels move only on request, so soft-trigger runs see a steady input A
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_input_a <= 1'h0;
            trigger_input_b <= 1'h0;
            out_q <= 1'h0;
            toggles <= 0;
            gap <= 0;
            cyc_q <= 0;
            last_q <= 0;
        end else begin
            cyc_q <= cyc_q + 1;
            out_q <= timer_output_pin;
            if (flip_a) trigger_input_a <= ~trigger_input_a;
            if (flip_b) trigger_input_b <= ~trigger_input_b;
            if (timer_output_pin != out_q) begin
                toggles <= toggles + 1;
                gap <= cyc_q - last_q;
                last_q <= cyc_q;
            end
        end
    end
endmodule : pulse_source

// ==== bench/timer_capture_pulse_unit_tb.sv ====
`timescale 1ns/10ps
module timer_capture_pulse_unit_tb;
    // ==========================================================
    // Signals
    localparam int TMO = 80000;
    logic pclk, presetn, psel, penable, pwrite, fa, fb, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, t0;
    logic pready, pslverr, tia, tib, top, ia, ib;
    int errors, total_checks, cyc, na, nb, la, pa, lb, pb, tog, gap, m, n, k;

    timer_capture_pulse_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_input_a(tia),
        .trigger_input_b(tib), .timer_output_pin(top), .irq_reg_a(ia), .irq_reg_b(ib));
    pulse_source src (.pclk(pclk), .presetn(presetn), .flip_a(fa), .flip_b(fb),
        .timer_output_pin(top), .trigger_input_a(tia), .trigger_input_b(tib),
        .toggles(tog), .gap(gap));

    // ==========================================================
    // Tasks and expectations
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic flip(input logic a, input logic b);
        @(posedge pclk);
        fa <= a;
        fb <= b;
        @(posedge pclk);
        fa <= 1'h0;
        fb <= 1'h0;
    endtask : flip
    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask : idle
    task automatic wrap_up;
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    function automatic logic [31:0] mword(input logic [1:0] op, input logic tg);
        return {28'h0, op, tg, 1'h0};
    endfunction : mword
    function automatic logic [31:0] exp_edges(input logic [1:0] es);
        case (es)
            tcpu_pkg::ES_FALL, tcpu_pkg::ES_RISE: return 32'h1;
            tcpu_pkg::ES_BOTH: return 32'h2;
            default: return 32'h0;
        endcase
    endfunction : exp_edges

    // ==========================================================
    // Clock and event monitor
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ia === 1'h1) begin
            pa <= la;
            la <= cyc;
            na <= na + 1;
        end
        if (ib === 1'h1) begin
            pb <= lb;
            lb <= cyc;
            nb <= nb + 1;
        end
        if (cyc == TMO) begin
            errors++;
            wrap_up();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, fa, fb, paddr, pwdata} = '0;
        void'($urandom(21347));
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        chk("ready", 32'h1, {31'h0, pready});
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_FREE, 1'h0));
        apb(1'h0, tcpu_pkg::OFS_COUNT, 32'h0);
        t0 = rd;
        k = $urandom_range(7, 0);
        idle(k);
        apb(1'h0, tcpu_pkg::OFS_COUNT, 32'h0);
        chk("count step", 32'(k + 3), {16'h0, rd[15:0] - t0[15:0]});
        apb(1'h1, tcpu_pkg::OFS_CAPCTL, 32'h5);
        apb(1'h1, tcpu_pkg::OFS_PRESC, 32'hF0);
        apb(1'h1, tcpu_pkg::OFS_OUTCTL, 32'h1);
        k = $urandom_range(40, 0);
        flip(1'h1, 1'h0);
        idle(k);
        flip(1'h0, 1'h1);
        idle(8);
        apb(1'h0, tcpu_pkg::OFS_REG_A, 32'h0);
        t0 = rd;
        apb(1'h0, tcpu_pkg::OFS_REG_B, 32'h0);
        chk("capture gap", 32'(k + 2), {16'h0, t0[15:0] - rd[15:0]});
        t0 = tog;
        for (int es = 0; es < 4; es++) begin
            apb(1'h1, tcpu_pkg::OFS_PRESC, 32'hC0 + 32'(es * 16));
            apb(1'h1, tcpu_pkg::OFS_REG_B, 32'h5A5A);
            k = nb;
            flip(1'h1, 1'h1);
            idle(8);
            flip(1'h1, 1'h1);
            idle(8);
            chk("edges taken", exp_edges(2'(es)), 32'(nb - k));
            apb(1'h0, tcpu_pkg::OFS_REG_B, 32'h0);
            if (es == 2) chk("no B capture", 32'h5A5A, rd);
        end
        chk("output held", t0, tog);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_FREE, 1'h1));
        t0 = tog;
        flip(1'h1, 1'h0);
        idle(8);
        flip(1'h1, 1'h0);
        idle(8);
        chk("capture toggle", t0 + 2, tog);
        // Pulse generation, B kept below A
        m = $urandom_range(60, 20);
        n = $urandom_range(m - 1, 0);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_STOP, 1'h0));
        apb(1'h1, tcpu_pkg::OFS_CAPCTL, 32'h0);
        apb(1'h1, tcpu_pkg::OFS_REG_A, m);
        apb(1'h1, tcpu_pkg::OFS_REG_B, n);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_PPG, 1'h0));
        idle(3 * m + 6);
        chk("period A", m + 1, la - pa);
        chk("period B", m + 1, lb - pb);
        chk("B to A", (la > lb) ? m - n : n + 1, (la > lb) ? la - lb : lb - la);
        chk("output gap", (la > lb) ? m - n : n + 1, gap);
        // One-shot from the soft trigger, A and B kept apart
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_STOP, 1'h0));
        m = $urandom_range(30, 5);
        n = m + $urandom_range(30, 1);
        apb(1'h1, tcpu_pkg::OFS_REG_A, m);
        apb(1'h1, tcpu_pkg::OFS_REG_B, n);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_FREE, 1'h0));
        apb(1'h1, tcpu_pkg::OFS_OUTCTL, 32'h21);
        t0 = tog;
        apb(1'h1, tcpu_pkg::OFS_OUTCTL, 32'h61);
        idle(3 * n + 8);
        chk("single pulse", t0 + 2, tog);
        chk("pulse width", n - m, gap);
        chk("B after A", n - m, lb - la);
        // Width measurement: falling edge of input A restarts, rising edge captures A
        apb(1'h1, tcpu_pkg::OFS_OUTCTL, 32'h1);
        apb(1'h1, tcpu_pkg::OFS_CAPCTL, 32'h7);
        apb(1'h1, tcpu_pkg::OFS_PRESC, 32'h0);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_EDGE_CLEAR, 1'h0));
        t0 = tog;
        k = na;
        m = $urandom_range(40, 0);
        flip(1'h1, 1'h0);
        idle(m);
        flip(1'h1, 1'h0);
        idle(8);
        apb(1'h0, tcpu_pkg::OFS_REG_A, 32'h0);
        chk("low width", 32'(m + 1), rd);
        chk("reverse silent", k, na);
        chk("clear toggle", t0 + 1, tog);
        // Start from a stopped counter so the clear lands far from a wrap
        apb(1'h1, tcpu_pkg::OFS_OUTCTL, 32'h0);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_STOP, 1'h0));
        apb(1'h0, tcpu_pkg::OFS_COUNT, 32'h0);
        chk("stopped count", 32'h0, rd);
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_FREE, 1'h0));
        idle(65540);
        apb(1'h0, tcpu_pkg::OFS_MODE, 32'h0);
        chk("overflow set", 32'h1, {31'h0, rd[0]});
        apb(1'h1, tcpu_pkg::OFS_MODE, mword(tcpu_pkg::OP_FREE, 1'h0));
        apb(1'h0, tcpu_pkg::OFS_MODE, 32'h0);
        chk("overflow cleared", 32'h0, {31'h0, rd[0]});
        wrap_up();
    end
endmodule : timer_capture_pulse_unit_tb
